// ### design/dps_sequencer.sv
// dps_sequencer: power-up and scan sequencer for a disk controller.
// assumes a stepper that pulses seekDone and a read channel that pulses a done/ok pair.
`timescale 1ns/1ps

module dps_sequencer
   import dps_pkg::*;
#(
   parameter longint SPIN_CYC = SPIN_DELAY_CYC,
   parameter longint BLINK_CYC = BLINK_HALF_CYC,
   parameter longint TIMEOUT_CYC = READ_TIMEOUT_CYC
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic supplyPowerGood,
   input wire logic seekDone,
   input wire dps_resp_t readResp,
   input wire logic spareEntry,
   input wire dps_addr_t spareAddr,
   output logic seekReq,
   output dps_addr_t seekTarget,
   output logic readReq,
   output dps_addr_t readAddr,
   output logic writeEnable,
   output logic readyLamp,
   output logic scanBusy,
   output logic scanDone,
   output logic scanFailed,
   output logic spareFull
);

   // ----------------------------------------------------------------
   // state and synchronisers
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_WAIT_PWR, ST_SPIN, ST_SEEK, ST_READ_SPARES, ST_SEEK_SCAN,
      ST_READ_SCAN, ST_RECOVER, ST_DONE, ST_PARKED
   } dps_state_t;

   localparam int TMR_W = 33;

   dps_state_t state_q, state_d;
   logic pgMeta_q, pgSync_q;
   logic [TRY_W-1:0] try_q;
   logic [TRY_W-1:0] recTry_q;
   logic [TRACK_W-1:0] target_q;
   logic spareDone_q;
   dps_addr_t addr_q;
   logic lamp_q;
   logic seekReq_q, readReq_q;
   logic timerLoad;
   logic [TMR_W-1:0] timerCount;
   logic timerExpired;
   logic timerRunning;
   logic blinkLoad;
   logic blinkExpired;
   logic blinkRunning;
   logic readFail;
   dps_addr_t nextAddr;

   // power good comes from the supply, outside this clock's domain
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pgMeta_q <= 1'b0;
         pgSync_q <= 1'b0;
      end
      else
      begin
         pgMeta_q <= supplyPowerGood;
         pgSync_q <= pgMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // next sector in ascending order: sector, then surface, then track
   function automatic dps_addr_t next_addr(input dps_addr_t a);
      dps_addr_t n;
      n = a;
      if (a.sector != SEC_LAST)
         n.sector = a.sector + 1'b1;
      else
      begin
         n.sector = SEC_ZERO;
         if (a.surface != SURF_LAST)
            n.surface = a.surface + 1'b1;
         else
         begin
            n.surface = SURF_ZERO;
            n.track = a.track + 1'b1;
         end
      end
      return n;
   endfunction : next_addr

   function automatic logic last_addr(input dps_addr_t a);
      return (a.track == TRK_LAST) && (a.surface == SURF_LAST) && (a.sector == SEC_LAST);
   endfunction : last_addr

   // one timer shared: spin-up delay and read timeouts never overlap
   dps_timer #(.CNT_W(TMR_W)) u_timer (
      .clock(clock),
      .rst(rst),
      .load(timerLoad),
      .count(timerCount),
      .running(timerRunning),
      .expired(timerExpired)
   );

   dps_timer #(.CNT_W(TMR_W)) u_blink (
      .clock(clock),
      .rst(rst),
      .load(blinkLoad),
      .count(TMR_W'(BLINK_CYC - 1)),
      .running(blinkRunning),
      .expired(blinkExpired)
   );

   dps_spare_table #(.SLOTS(SPARE_SLOTS)) u_spares (
      .clock(clock),
      .rst(rst),
      .clear(state_q == ST_SEEK && state_d == ST_READ_SPARES && try_q == TRY_FIRST),
      .wrEn(spareEntry && state_q == ST_READ_SPARES),
      .wrAddr(spareAddr),
      .used(),
      .full(spareFull)
   );

   // a read attempt fails on a bad answer or on timeout
   // an answer in the same cycle as the timeout wins over the timeout
   assign readFail = (readResp.done && !readResp.ok) || (timerExpired && !readResp.done);
   assign nextAddr = next_addr(addr_q);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      timerLoad = 1'b0;
      timerCount = TMR_W'(TIMEOUT_CYC - 1);
      case (state_q)
         ST_WAIT_PWR:
            if (pgSync_q)
            begin
               state_d = ST_SPIN;
               timerLoad = 1'b1;
               timerCount = TMR_W'(SPIN_CYC - 1);
            end
         ST_SPIN:
            if (timerExpired)
               state_d = ST_SEEK;
         ST_SEEK:
            if (seekDone)
            begin
               if (target_q == TRK_SPARES)
               begin
                  state_d = ST_READ_SPARES;
                  timerLoad = 1'b1;
               end
               else if (target_q == TRK_PARK && try_q == RECOVER_RETRIES && spareDone_q)
                  state_d = ST_PARKED;
               else
                  state_d = ST_SEEK; // recovery excursion finished, head back to 77
            end
         ST_READ_SPARES:
            if (readResp.done && readResp.ok)
               state_d = ST_SEEK_SCAN;
            else if (readFail)
               state_d = ST_SEEK;
         ST_SEEK_SCAN:
            if (seekDone)
            begin
               state_d = ST_READ_SCAN;
               timerLoad = 1'b1;
            end
         ST_READ_SCAN:
            if (readResp.done && readResp.ok)
            begin
               if (last_addr(addr_q))
                  state_d = ST_DONE;
               else
               begin
                  timerLoad = 1'b1;
                  if (nextAddr.track != addr_q.track)
                     state_d = ST_SEEK_SCAN;
               end
            end
            else if (readFail && recTry_q == RECOVER_RETRIES && last_addr(addr_q))
               state_d = ST_DONE; // final sector given up, nothing left to skip to
            else if (readFail)
               state_d = ST_RECOVER;
         ST_RECOVER:
            if (seekDone)
            begin
               state_d = ST_READ_SCAN;
               timerLoad = 1'b1;
            end
         ST_DONE, ST_PARKED:
            state_d = state_q;
         default:
            state_d = ST_WAIT_PWR;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         state_q <= ST_WAIT_PWR;
      else
         state_q <= state_d;
   end

   // ----------------------------------------------------------------
   // spares retry path: 77, then 0 and back, then 155 and back, then park
   // ----------------------------------------------------------------
   // spareDone_q marks that the last attempt was used so the next park is final
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         target_q <= TRK_SPARES;
         try_q <= TRY_FIRST;
         spareDone_q <= 1'b0;
      end
      else if (state_q == ST_READ_SPARES && readFail && !(readResp.done && readResp.ok))
      begin
         if (try_q == TRY_FIRST)
         begin
            target_q <= TRK_ZERO;
            try_q <= TRY_AFTER_ZERO;
         end
         else if (try_q == TRY_AFTER_ZERO)
         begin
            target_q <= TRK_PARK;
            try_q <= TRY_AFTER_PARK;
         end
         else
         begin
            target_q <= TRK_PARK;
            spareDone_q <= 1'b1;
         end
      end
      else if (state_q == ST_SEEK && seekDone && target_q != TRK_SPARES && !spareDone_q)
         target_q <= TRK_SPARES;
   end

   // ----------------------------------------------------------------
   // scan address and recovery bookkeeping
   // ----------------------------------------------------------------
   // recovery re-seeks the current track once per retry, then skips the sector
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         addr_q <= '{track: TRK_ZERO, surface: SURF_ZERO, sector: SEC_ZERO};
         recTry_q <= TRY_FIRST;
      end
      else if (state_q == ST_READ_SPARES && readResp.done && readResp.ok)
         addr_q <= '{track: TRK_ZERO, surface: SURF_ZERO, sector: SEC_ZERO};
      else if (state_q == ST_READ_SCAN && readResp.done && readResp.ok && !last_addr(addr_q))
      begin
         addr_q <= next_addr(addr_q);
         recTry_q <= TRY_FIRST;
      end
      else if (state_q == ST_READ_SCAN && readFail)
      begin
         if (recTry_q == RECOVER_RETRIES && !last_addr(addr_q))
         begin
            addr_q <= next_addr(addr_q); // give up on this sector
            recTry_q <= TRY_FIRST;
         end
         else
            recTry_q <= recTry_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // stepper and read channel requests
   // ----------------------------------------------------------------
   // requests are held until the far side answers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         seekReq_q <= 1'b0;
         readReq_q <= 1'b0;
      end
      else
      begin
         seekReq_q <= (state_d == ST_SEEK) || (state_d == ST_SEEK_SCAN) ||
                      (state_d == ST_RECOVER);
         readReq_q <= (state_d == ST_READ_SPARES) || (state_d == ST_READ_SCAN);
      end
   end

   assign seekReq = seekReq_q && !seekDone;
   assign readReq = readReq_q && !readResp.done;
   assign seekTarget = '{track: (state_q == ST_SEEK) ? target_q : addr_q.track,
                         surface: SURF_ZERO, sector: SEC_ZERO};
   assign readAddr = (state_q == ST_READ_SPARES) ?
      dps_addr_t'{track: TRK_SPARES, surface: (try_q[0] ? SURF_SPARES_B : SURF_SPARES_A),
        sector: SEC_ZERO} : addr_q;
   // scan never writes; keep the gate explicit so nothing can write mid-seek
   assign writeEnable = 1'b0 && !seekReq_q;

   // ----------------------------------------------------------------
   // ready lamp
   // ----------------------------------------------------------------
   // lit at power-on, dark once power is good, toggling through the sector scan
   assign blinkLoad = (state_q == ST_READ_SCAN || state_q == ST_SEEK_SCAN ||
                       state_q == ST_RECOVER) && (!blinkRunning || blinkExpired);

   always_ff @(posedge clock)
   begin
      if (rst)
         lamp_q <= 1'b1;
      else if (state_q == ST_WAIT_PWR && pgSync_q)
         lamp_q <= 1'b0;
      else if (blinkExpired && state_q inside {ST_READ_SCAN, ST_SEEK_SCAN, ST_RECOVER})
         lamp_q <= !lamp_q;
      else if (state_q == ST_DONE)
         lamp_q <= 1'b1;
      else if (state_q == ST_PARKED)
         lamp_q <= 1'b0;
   end

   assign readyLamp = lamp_q;
   assign scanBusy = !(state_q inside {ST_WAIT_PWR, ST_DONE, ST_PARKED});
   assign scanDone = (state_q == ST_DONE);
   assign scanFailed = (state_q == ST_PARKED);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_idle_no_activity:
   assert property (@(posedge clock) disable iff (rst)
      !pgSync_q |-> !seekReq && !readReq)
      else $error("activity before power good");

   a_lamp_off_pg:
   assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_WAIT_PWR && pgSync_q) |=> !readyLamp)
      else $error("lamp not off at power good");

   a_spin_hold_seek:
   assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_SPIN) |-> !seekReq && timerRunning)
      else $error("seek during spin-up");

   a_first_seek_spares:
   assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_SPIN && timerExpired) |=> seekTarget.track == TRK_SPARES)
      else $error("first seek not to spares track");

   a_retry_to_zero:
   assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_READ_SPARES && readFail && try_q == TRY_FIRST)
      |=> state_q == ST_SEEK && target_q == TRK_ZERO)
      else $error("first recovery not via track 0");

   a_retry_to_park:
   assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_READ_SPARES && readFail && try_q == TRY_AFTER_ZERO)
      |=> target_q == TRK_PARK && !spareDone_q)
      else $error("second recovery not via park");

   a_abandon_park:
   assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_SEEK && seekDone && spareDone_q) |=> state_q == ST_PARKED)
      else $error("abandon did not park");

   a_scan_from_zero:
   assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_READ_SPARES && readResp.done && readResp.ok)
      |=> addr_q.track == TRK_ZERO && addr_q.sector == SEC_ZERO)
      else $error("scan does not start at sector 0");

   a_no_write_seek:
   assert property (@(posedge clock) disable iff (rst)
      seekReq_q |-> !writeEnable)
      else $error("write enabled during seek");

   a_parked_quiet:
   assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_PARKED) |=> scanFailed && !readReq && !seekReq)
      else $error("activity after abandon");

endmodule : dps_sequencer

// ### design/dps_pkg.sv
// dps_pkg: shared constants and carrier types for the power-up scan sequencer.
// assumes a 200 MHz system clock and a stepper/read channel that answers with done pulses.
package dps_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam longint SPIN_DELAY_S = 20;
   localparam longint SPIN_DELAY_CYC = SPIN_DELAY_S * 1000000000 / CLK_PERIOD_NS;
   localparam longint BLINK_HALF_MS = 250;
   localparam longint BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
   localparam longint READ_TIMEOUT_MS = 100;
   localparam longint READ_TIMEOUT_CYC = READ_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int TRACK_W = 8;
   localparam int SECTOR_W = 5;
   localparam int SURF_W = 2;
   localparam logic [TRACK_W-1:0] TRK_ZERO = 8'h00;
   localparam logic [TRACK_W-1:0] TRK_SPARES = 8'h4D;   // track 77
   localparam logic [TRACK_W-1:0] TRK_PARK = 8'h9B;     // track 155
   localparam logic [TRACK_W-1:0] TRK_LAST = 8'h99;     // last data track, 153
   localparam logic [SECTOR_W-1:0] SEC_ZERO = 5'h00;
   localparam logic [SECTOR_W-1:0] SEC_LAST = 5'h0F;
   localparam logic [SURF_W-1:0] SURF_ZERO = 2'h0;
   localparam logic [SURF_W-1:0] SURF_SPARES_A = 2'h2;
   localparam logic [SURF_W-1:0] SURF_SPARES_B = 2'h3;
   localparam logic [SURF_W-1:0] SURF_LAST = 2'h3;
   localparam int SPARE_SLOTS = 32;
   localparam int ADDR_W = TRACK_W + SURF_W + SECTOR_W;
   localparam int TRY_W = 2;
   localparam logic [TRY_W-1:0] TRY_FIRST = 2'h0;
   localparam logic [TRY_W-1:0] TRY_AFTER_ZERO = 2'h1;
   localparam logic [TRY_W-1:0] TRY_AFTER_PARK = 2'h2;
   localparam logic [TRY_W-1:0] RECOVER_RETRIES = 2'h2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [TRACK_W-1:0] track;
      logic [SURF_W-1:0] surface;
      logic [SECTOR_W-1:0] sector;
   } dps_addr_t;

   typedef struct packed
   {
      logic done;
      logic ok;
   } dps_resp_t;

   typedef struct packed
   {
      logic valid;
      dps_addr_t addr;
   } dps_spare_t;

endpackage : dps_pkg

// ### design/dps_timer.sv
// dps_timer: loadable down-counter that pulses expired when it reaches zero.
// assumes load and the count come from the sequencer on the same clock.
`timescale 1ns/1ps
module dps_timer
   import dps_pkg::*;
#(
   parameter int CNT_W = 33
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic load,
   input wire logic [CNT_W-1:0] count,
   output logic running,
   output logic expired
);

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q;
   logic run_q;

   // load restarts; a zero load expires on the next edge
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end
      else if (load)
      begin
         cnt_q <= count;
         run_q <= 1'b1;
      end
      else if (run_q)
      begin
         if (cnt_q == '0)
            run_q <= 1'b0;
         else
            cnt_q <= cnt_q - 1'b1;
      end
   end

   assign running = run_q;
   // load must not mask expired: callers reload on expiry, which would close a loop
   assign expired = run_q && (cnt_q == '0);

endmodule : dps_timer

// ### design/dps_spare_table.sv
// dps_spare_table: holds relocated sector entries captured from the spares track.
// assumes entries arrive one at a time as a packed record with a write strobe.
`timescale 1ns/1ps
module dps_spare_table
   import dps_pkg::*;
#(
   parameter int SLOTS = SPARE_SLOTS
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic wrEn,
   input wire dps_addr_t wrAddr,
   output logic [$clog2(SLOTS+1)-1:0] used,
   output logic full
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   dps_spare_t table_q [SLOTS];
   logic [$clog2(SLOTS+1)-1:0] used_q;

   // entries beyond the last slot are dropped; full tells the sequencer
   always_ff @(posedge clock)
   begin
      if (rst || clear)
         used_q <= '0;
      else if (wrEn && !full)
         used_q <= used_q + 1'b1;
   end

   // record each relocated sector in the next free slot
   always_ff @(posedge clock)
   begin
      if (wrEn && !full)
         table_q[used_q[$clog2(SLOTS)-1:0]] <= '{valid: 1'b1, addr: wrAddr};
   end

   assign used = used_q;
   assign full = (used_q == SLOTS[$clog2(SLOTS+1)-1:0]);

endmodule : dps_spare_table

// ### bench/dps_disk_model.sv
// dps_disk_model: stepper and read channel facing the scan sequencer.
// assumes requests stand until their done pulse, on the sequencer's clock.
`timescale 1ns/1ps
module dps_disk_model
   import dps_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic seekReq,
   input wire logic readReq,
   input wire dps_addr_t readAddr,
   input wire logic mute,
   input wire logic [1:0] spFail,
   input wire logic faultOn,
   input wire dps_addr_t faultAddr,
   output logic seekDone,
   output dps_resp_t readResp,
   output logic spareEntry,
   output dps_addr_t spareAddr
);
   int sCnt;
   int rCnt;
   int rN;
   logic fl;
   logic hit;
   logic fUsed;

   // quiet outputs before the first edge
   initial
   begin
      seekDone = 1'b0;
      readResp = '0;
      spareEntry = 1'b0;
      spareAddr = '0;
   end

   // --------------------------------------------------
   // stepper
   // --------------------------------------------------
   // random settle time, so no fixed latency is relied upon
   always @(posedge clock)
   begin
      seekDone <= 1'b0;
      if (rst || sCnt == 1)
         sCnt <= 0;
      else if (sCnt > 1)
         sCnt <= sCnt - 1;
      else if (seekReq)
         sCnt <= 1 + $urandom % 4;
      if (!rst && sCnt == 1)
         seekDone <= 1'b1;
   end

   // --------------------------------------------------
   // read channel
   // --------------------------------------------------
   // the first spFail reads fail, then one chosen sector fails once
   assign fl = rN <= spFail;
   assign hit = faultOn && !fUsed && rN > spFail + 1 && readAddr === faultAddr;

   // entry data changes every cycle, so a stale value is never mistaken for a new one
   always @(posedge clock)
   begin
      readResp <= '0;
      spareEntry <= 1'b0;
      spareAddr <= dps_addr_t'($urandom);
      if (rst)
      begin
         rCnt <= 0;
         rN <= 0;
         fUsed <= 1'b0;
      end
      else if (rCnt != 0 && !readReq)
         rCnt <= 0;
      else if (rCnt == 0 && readReq)
      begin
         rN <= rN + 1;
         rCnt <= (rN == spFail) ? 40 : 1 + $urandom % 2;
      end
      else if (rCnt > 1)
      begin
         rCnt <= rCnt - 1;
         spareEntry <= rN == spFail + 1;
      end
      else if (rCnt == 1 && !(fl && mute))
      begin
         rCnt <= 0;
         readResp.done <= 1'b1;
         readResp.ok <= !(fl || hit);
         fUsed <= fUsed | hit;
      end
   end
endmodule : dps_disk_model

// ### bench/test_disk_powerup_scan_sequencer.sv
// test_disk_powerup_scan_sequencer: self-checking bench for the scan sequencer.
// assumes short spin, blink and timeout counts and the disk model as far side.
`timescale 1ns/1ps
module test_disk_powerup_scan_sequencer
   import dps_pkg::*;
;
   localparam logic [7:0] FAIL_LOG [6] = '{TRK_SPARES, TRK_ZERO, TRK_SPARES, TRK_PARK,
      TRK_SPARES, TRK_PARK};
   localparam logic [7:0] PASS_LOG [6] = '{TRK_SPARES, TRK_ZERO, TRK_SPARES, TRK_PARK,
      TRK_SPARES, TRK_ZERO};
   logic clock, rst, supplyPowerGood, seekDone, spareEntry, seekReq, readReq;
   logic writeEnable, readyLamp, scanBusy, scanDone, scanFailed, spareFull;
   logic mute, faultOn, sPrev, rPrev, lPrev;
   logic [1:0] spFail, firstSurf;
   dps_resp_t readResp;
   dps_addr_t spareAddr, seekTarget, readAddr, faultAddr, lastA, expA;
   logic [TRACK_W-1:0] seekLog [$];
   int err_count, checked, cyc, rdN, ordErr, rtyN, blinks, weBad, n;

   dps_sequencer #(.SPIN_CYC(50), .BLINK_CYC(4), .TIMEOUT_CYC(60)) dps_sequencer_i
   (
      .clock(clock), .rst(rst), .supplyPowerGood(supplyPowerGood),
      .seekDone(seekDone), .readResp(readResp), .spareEntry(spareEntry),
      .spareAddr(spareAddr), .seekReq(seekReq), .seekTarget(seekTarget),
      .readReq(readReq), .readAddr(readAddr), .writeEnable(writeEnable),
      .readyLamp(readyLamp), .scanBusy(scanBusy), .scanDone(scanDone),
      .scanFailed(scanFailed), .spareFull(spareFull)
   );

   dps_disk_model dps_disk_model_i
   (
      .clock(clock), .rst(rst), .seekReq(seekReq), .readReq(readReq),
      .readAddr(readAddr), .mute(mute), .spFail(spFail), .faultOn(faultOn),
      .faultAddr(faultAddr), .seekDone(seekDone), .readResp(readResp),
      .spareEntry(spareEntry), .spareAddr(spareAddr)
   );

   // --------------------------------------------------
   // helpers
   // --------------------------------------------------
   // scan order: sector, then surface, then track
   function automatic dps_addr_t nextA(input dps_addr_t a);
      dps_addr_t r;
      r = a;
      r.sector = a.sector + 5'h01;
      if (a.sector == SEC_LAST)
      begin
         r.sector = SEC_ZERO;
         r.surface = a.surface + 2'h1;
         if (a.surface == SURF_LAST)
            r.track = a.track + 8'h01;
      end
      return r;
   endfunction : nextA

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask : cmp

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   task automatic do_reset();
      @(posedge clock);
      rst <= 1'b1;
      supplyPowerGood <= 1'b0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      seekLog.delete();
      rdN = 0;
      ordErr = 0;
      rtyN = 0;
      blinks = 0;
      expA = '0;
      lastA = '1;
   endtask : do_reset

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // --------------------------------------------------
   // monitor
   // --------------------------------------------------
   // logs seek targets and read starts; a repeated address is a retry
   always @(posedge clock)
   begin
      cyc++;
      if (cyc > 95000)
      begin
         err_count++;
         end_of_test();
      end
      if (seekReq && !sPrev)
         seekLog.push_back(seekTarget.track);
      if (readReq && !rPrev)
      begin
         rdN++;
         if (rdN == 1)
            firstSurf = readAddr.surface;
         else if (rdN > spFail + 1 && readAddr === lastA)
            rtyN++;
         else if (rdN > spFail + 1)
         begin
            ordErr += (readAddr !== expA);
            expA = nextA(readAddr);
         end
         lastA = readAddr;
      end
      if (rdN > spFail + 1 && readyLamp !== lPrev && !scanDone)
         blinks++;
      if (writeEnable !== 1'b0)
         weBad++;
      sPrev = seekReq;
      rPrev = readReq;
      lPrev = readyLamp;
   end

   // --------------------------------------------------
   // tests
   // --------------------------------------------------
   initial
   begin
      void'($urandom(74681));
      rst = 1'b1;
      supplyPowerGood = 1'b0;
      mute = 1'b1;
      spFail = 2'h3;
      faultOn = 1'b0;
      faultAddr = '0;
      // spares track never answers: timeouts drive the whole recovery path
      do_reset();
      repeat (20 + $urandom % 40) @(posedge clock);
      @(negedge clock);
      cmp("idle seeks", 0, seekLog.size());
      cmp("idle reads", 0, rdN);
      cmp("lamp at reset", 1, readyLamp);
      cmp("idle busy", 0, scanBusy);
      @(posedge clock);
      supplyPowerGood <= 1'b1;
      repeat (4) @(posedge clock);
      @(negedge clock);
      cmp("lamp off", 0, readyLamp);
      n = 4;
      while (!seekReq && n < 200)
      begin
         @(posedge clock);
         n++;
      end
      cmp("spin wait", 1, n >= 50 && n <= 60);
      cmp("first seek", TRK_SPARES, seekTarget.track);
      cmp("busy seeking", 1, scanBusy);
      for (n = 0; n < 3000 && !scanFailed; n++) @(posedge clock);
      cmp("spares surface", SURF_SPARES_A, firstSurf);
      cmp("seek count", 6, seekLog.size());
      for (n = 0; n < 6; n++) cmp("seek order", FAIL_LOG[n], seekLog[n]);
      repeat (50) @(posedge clock);
      @(negedge clock);
      cmp("parked seeks", 6, seekLog.size());
      cmp("timed out reads", 3, rdN);
      cmp("failed flag", 1, scanFailed);
      cmp("parked requests", 0, {seekReq, readReq});
      cmp("spares not full", 0, spareFull);
      cmp("lamp parked", 0, readyLamp);
      cmp("busy parked", 0, scanBusy);
      $display("test abandon done");
      // third spares attempt passes, then a full scan with one faulty sector
      do_reset();
      mute <= 1'b0;
      spFail <= 2'h2;
      faultOn <= 1'b1;
      faultAddr <= {8'($urandom % 154), 2'($urandom), 5'($urandom % 16)};
      supplyPowerGood <= 1'b1;
      for (n = 0; n < 90000 && !scanDone; n++) @(posedge clock);
      @(negedge clock);
      for (n = 0; n < 6; n++) cmp("seek order", PASS_LOG[n], seekLog[n]);
      cmp("scan done", 1, scanDone);
      cmp("scan failed", 0, scanFailed);
      cmp("lamp done", 1, readyLamp);
      cmp("busy done", 0, scanBusy);
      cmp("read order", 0, ordErr);
      cmp("last sector", {TRK_LAST, SURF_LAST, SEC_LAST}, lastA);
      cmp("fault retries", 1, rtyN);
      cmp("lamp blinked", 1, blinks > 100);
      cmp("spares full", 1, spareFull);
      cmp("write enables", 0, weBad);
      $display("test full scan done");
      end_of_test();
   end
endmodule : test_disk_powerup_scan_sequencer
